/* pkg/xcv_pkg.sv */
// Types shared by the transceiver design
`default_nettype none
package xcv_pkg;
	`include "xcv_regs.svh"

	// Data word of one port
	typedef logic [`XCV_DATA_W-1:0] xcv_data_t;

	// Per-direction control bits, packed in register bit order
	typedef struct packed {
		logic rev_clock;
		logic rev_latch_enable;
		logic rev_output_enable_n;
		logic fwd_clock;
		logic fwd_latch_enable;
		logic fwd_output_enable;
	} xcv_ctrl_s;

	// One tri-state port as seen at the module boundary
	typedef struct packed {
		xcv_data_t data;
		xcv_data_t oe;
	} xcv_pin_out_s;
endpackage
`default_nettype wire

/* pkg/xcv_regs.svh */
// Register offsets, field positions, reset values and widths of the transceiver
`ifndef XCV_REGS_SVH
`define XCV_REGS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define XCV_DATA_W 18
`define XCV_ADDR_W 5

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define XCV_CTRL_OFS 5'h0_0
`define XCV_FWD_DATA_OFS 5'h0_4
`define XCV_REV_DATA_OFS 5'h0_8
`define XCV_PORT_A_OFS 5'h0_C
`define XCV_PORT_B_OFS 5'h1_0

// ----------------------------------------------------------------
// Control field positions and reset value
// ----------------------------------------------------------------
`define XCV_CTRL_FWD_OE_BIT 0
`define XCV_CTRL_FWD_LE_BIT 1
`define XCV_CTRL_FWD_CLK_BIT 2
`define XCV_CTRL_REV_OE_N_BIT 3
`define XCV_CTRL_REV_LE_BIT 4
`define XCV_CTRL_REV_CLK_BIT 5
`define XCV_CTRL_W 6
`define XCV_CTRL_RESET 6'h0_8

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define XCV_RESP_OKAY 2'h0
`define XCV_RESP_SLVERR 2'h2

`endif

/* rtl/xcv_transceiver.sv */
// Eighteen-bit two-way bus transceiver with AXI4-Lite control and status
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`include "xcv_regs.svh"
`default_nettype none

module xcv_transceiver
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	// Port A pins
	input wire xcv_pkg::xcv_data_t a_data_in,
	input wire logic a_drive_in,
	output logic [`XCV_DATA_W-1:0] a_data_out,
	output logic [`XCV_DATA_W-1:0] a_data_oe_out,
	// Port B pins
	input wire xcv_pkg::xcv_data_t b_data_in,
	input wire logic b_drive_in,
	output logic [`XCV_DATA_W-1:0] b_data_out,
	output logic [`XCV_DATA_W-1:0] b_data_oe_out,
	// AXI4-Lite slave
	input wire logic [`XCV_ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [`XCV_ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in
);
	import xcv_pkg::*;

	// ----------------------------------------------------------------
	// Control register and per-direction views
	// ----------------------------------------------------------------
	xcv_ctrl_s ctrl;
	logic [1:0] dir_le;
	logic [1:0] dir_clk;
	logic [1:0] dir_en;
	logic [1:0] clk_prev;
	logic [1:0] port_drive;
	xcv_data_t port_in [2];
	xcv_data_t port_seen [2];
	xcv_data_t port_hold [2];
	xcv_data_t store [2];
	xcv_data_t oe [2];

	// Index 0 is forward (A to B), index 1 is reverse (B to A)
	assign dir_le = {ctrl.rev_latch_enable, ctrl.fwd_latch_enable};
	assign dir_clk = {ctrl.rev_clock, ctrl.fwd_clock};
	assign dir_en = {~ctrl.rev_output_enable_n, ctrl.fwd_output_enable};
	assign port_drive = {b_drive_in, a_drive_in};
	assign port_in[0] = a_data_in;
	assign port_in[1] = b_data_in;

	// ----------------------------------------------------------------
	// Per-direction datapath: bus hold, store, output enable
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_dir
			// Port g feeds direction g; direction 1-g drives port g back
			always_comb
			begin
				if (port_drive[g] | oe[1-g][0])
					port_seen[g] = port_in[g];
				else
					port_seen[g] = port_hold[g];
			end

			// Bus hold keeper for an undriven port
			always_ff @(posedge clock_in or negedge rst_n_in)
			begin
				if (!rst_n_in)
					port_hold[g] <= 18'h0_0000;
				else
					port_hold[g] <= port_seen[g];
			end

			// Clock bits move only by register writes, so sampling each edge sees every fall
			// Previous clock level for falling-edge detection
			always_ff @(posedge clock_in or negedge rst_n_in)
			begin
				if (!rst_n_in)
					clk_prev[g] <= 1'b0;
				else
					clk_prev[g] <= dir_clk[g];
			end

			// Open latch has priority, so a clock fall while transparent adds nothing
			// Combined latch and flip-flop, one bit per data line
			always_ff @(posedge clock_in or negedge rst_n_in)
			begin
				if (!rst_n_in)
					store[g] <= 18'h0_0000;
				else if (dir_le[g])
					store[g] <= port_seen[g];
				else if (clk_prev[g] & ~dir_clk[g])
					store[g] <= port_seen[g];
				else
					store[g] <= store[g];
			end

			// Output enable for every line of the driven port
			always_ff @(posedge clock_in or negedge rst_n_in)
			begin
				if (!rst_n_in)
					oe[g] <= 18'h0_0000;
				else
					oe[g] <= {`XCV_DATA_W{dir_en[g]}};
			end
		end
	endgenerate

	// Port outputs straight from the stores and enables
	assign b_data_out = store[0];
	assign b_data_oe_out = oe[0];
	assign a_data_out = store[1];
	assign a_data_oe_out = oe[1];

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	logic aw_held;
	logic w_held;
	logic [`XCV_ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic aw_take;
	logic w_take;
	logic wr_do;
	logic wr_ok;
	logic b_done;

	assign aw_take = s_axi_awvalid_in & s_axi_awready_out;
	assign w_take = s_axi_wvalid_in & s_axi_wready_out;
	assign wr_do = aw_held & w_held & ~s_axi_bvalid_out;
	assign wr_ok = (aw_addr == `XCV_CTRL_OFS);
	assign b_done = s_axi_bvalid_out & s_axi_bready_in;

	// Write address capture, kept until the register write is done
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			aw_held <= 1'b0;
			aw_addr <= 5'h0_0;
		end
		else if (aw_take)
		begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr_in;
		end
		else if (wr_do)
			aw_held <= 1'b0;
	end

	// Write address ready; closed until the response is taken, so a held address is never overwritten
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			s_axi_awready_out <= 1'b1;
		else if (aw_take)
			s_axi_awready_out <= 1'b0;
		else if (b_done)
			s_axi_awready_out <= 1'b1;
	end

	// Write data capture, before or after the address
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end
		else if (w_take)
		begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata_in;
			w_strb <= s_axi_wstrb_in;
		end
		else if (wr_do)
			w_held <= 1'b0;
	end

	// Write data ready, reopened together with the address ready
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			s_axi_wready_out <= 1'b1;
		else if (w_take)
			s_axi_wready_out <= 1'b0;
		else if (b_done)
			s_axi_wready_out <= 1'b1;
	end

	// Write response
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= `XCV_RESP_OKAY;
		end
		else if (wr_do)
		begin
			s_axi_bvalid_out <= 1'b1;
			s_axi_bresp_out <= wr_ok ? `XCV_RESP_OKAY : `XCV_RESP_SLVERR;
		end
		else if (s_axi_bready_in)
			s_axi_bvalid_out <= 1'b0;
	end

	// Control register, low byte lane only
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			ctrl <= `XCV_CTRL_RESET;
		else if (wr_do & wr_ok & w_strb[0])
			ctrl <= w_data[`XCV_CTRL_W-1:0];
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	// Read decode
	always_comb
	begin
		next_rresp = `XCV_RESP_OKAY;
		case (s_axi_araddr_in)
			`XCV_CTRL_OFS: next_rdata = {26'h000_0000, ctrl};
			`XCV_FWD_DATA_OFS: next_rdata = {14'h0000, store[0]};
			`XCV_REV_DATA_OFS: next_rdata = {14'h0000, store[1]};
			`XCV_PORT_A_OFS: next_rdata = {14'h0000, port_seen[0]};
			`XCV_PORT_B_OFS: next_rdata = {14'h0000, port_seen[1]};
			default:
			begin
				next_rdata = 32'h0000_0000;
				next_rresp = `XCV_RESP_SLVERR;
			end
		endcase
	end

	logic ar_take;
	logic r_done;

	assign ar_take = s_axi_arvalid_in & s_axi_arready_out;
	assign r_done = s_axi_rvalid_out & s_axi_rready_in;

	// Read address ready; one read outstanding, so the answer is never overrun
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			s_axi_arready_out <= 1'b1;
		else if (ar_take)
			s_axi_arready_out <= 1'b0;
		else if (r_done)
			s_axi_arready_out <= 1'b1;
	end

	// Read answer, frozen from the take until the handshake
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0000_0000;
			s_axi_rresp_out <= `XCV_RESP_OKAY;
		end
		else if (ar_take)
		begin
			s_axi_rvalid_out <= 1'b1;
			s_axi_rdata_out <= next_rdata;
			s_axi_rresp_out <= next_rresp;
		end
		else if (r_done)
			s_axi_rvalid_out <= 1'b0;
	end
endmodule // xcv_transceiver
`default_nettype wire

/* testbench/tb_top.sv */
// Random and corner-case bench for the transceiver
`include "xcv_regs.svh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import xcv_pkg::*;
	logic clk = 0, rst_n = 0, fa = 0, fb = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	logic aw_r, w_r, bv, ar_r, rv;
	logic [3:0] hs;
	logic [4:0] awa = '0, ara = '0;
	logic [31:0] wd = '0, rd;
	logic [1:0] bresp, rresp;
	xcv_data_t va = '0, vb = '0, wa, wb, ao, aoe, bo, boe, v, xp;
	int miscompares = 0, n_compared = 0;
	assign hs = {bv, aw_r, rv, ar_r};
	xcv_transceiver i_xcv_transceiver (.clock_in(clk), .rst_n_in(rst_n), .a_data_in(wa), .a_drive_in(fa),
		.a_data_out(ao), .a_data_oe_out(aoe), .b_data_in(wb), .b_drive_in(fb), .b_data_out(bo),
		.b_data_oe_out(boe), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(aw_r),
		.s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(w_r),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(br), .s_axi_araddr_in(ara),
		.s_axi_arvalid_in(arv), .s_axi_arready_out(ar_r), .s_axi_rdata_out(rd), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rv), .s_axi_rready_in(rr));
	xcv_bus_partner i_far_a (.clock_in(clk), .drive_in(fa), .value_in(va), .dev_in(ao), .dev_oe_in(aoe),
		.wire_out(wa));
	xcv_bus_partner i_far_b (.clock_in(clk), .drive_in(fb), .value_in(vb), .dev_in(bo), .dev_oe_in(boe),
		.wire_out(wb));
	// 40 MHz clock
	initial
	begin
		forever #12.5 clk = ~clk;
	end
	task automatic finish_test();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Expected enable word of one whole port
	function automatic logic [31:0] oe_word(input logic en);
		return en ? 32'h0003_ffff : 32'h0000_0000;
	endfunction
	// Bounded wait for one handshake line
	task automatic wt(input int s);
		int n;
		for (n = 0; n < 50; n++)
		begin
			@(posedge clk);
			if (hs[s])
				break;
		end
		if (n == 50)
		begin
			miscompares++;
			finish_test();
		end
	endtask
	task automatic axw(input logic [4:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		wt(2);
		awv <= 1'b0;
		wv <= 1'b0;
		wt(3);
		br <= 1'b0;
		cmp("bresp", 32'(e), 32'(bresp));
	endtask
	task automatic axr(input logic [4:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		wt(0);
		arv <= 1'b0;
		wt(1);
		rr <= 1'b0;
		cmp("rdata", e, rd);
		cmp("rresp", 32'(r), 32'(rresp));
	endtask
	// Control write, then let the link settle
	task automatic ctl(input logic [5:0] c);
		axw(`XCV_CTRL_OFS, 32'(c), `XCV_RESP_OKAY);
		repeat (3) @(posedge clk);
	endtask
	initial
	begin
		void'($urandom(28257));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		cmp("a_oe", 0, 32'(aoe));
		cmp("b_oe", 0, 32'(boe));
		axr(`XCV_CTRL_OFS, 32'h0000_0008, `XCV_RESP_OKAY);
		fa <= 1'b1;
		v = xcv_data_t'($urandom);
		va <= v;
		ctl(6'h0b);
		cmp("b_data", 32'(v), 32'(bo));
		cmp("b_oe", oe_word(1'b1), 32'(boe));
		v = ~v;
		va <= v;
		ctl(6'h09);
		va <= ~v;
		repeat (2) @(posedge clk);
		cmp("b_data", 32'(v), 32'(bo));
		for (int i = 0; i < 6; i++)
		begin
			xp = v;
			v = xcv_data_t'($urandom);
			va <= v;
			ctl(6'h0d);
			cmp("b_data", 32'(xp), 32'(bo));
			ctl(6'h09);
			va <= ~v;
			repeat (2) @(posedge clk);
			cmp("b_data", 32'(v), 32'(bo));
		end
		ctl(6'h08);
		cmp("b_oe", 0, 32'(boe));
		axr(`XCV_FWD_DATA_OFS, 32'(v), `XCV_RESP_OKAY);
		fa <= 1'b0;
		fb <= 1'b1;
		v = xcv_data_t'($urandom);
		vb <= v;
		ctl(6'h10);
		cmp("a_data", 32'(v), 32'(ao));
		cmp("a_oe", oe_word(1'b1), 32'(aoe));
		ctl(6'h20);
		v = ~v;
		vb <= v;
		ctl(6'h00);
		cmp("a_data", 32'(v), 32'(ao));
		ctl(6'h08);
		cmp("a_oe", 0, 32'(aoe));
		fb <= 1'b0;
		repeat (2) @(posedge clk);
		axr(`XCV_PORT_B_OFS, 32'(v), `XCV_RESP_OKAY);
		axr(`XCV_PORT_A_OFS, 32'(v), `XCV_RESP_OKAY);
		axr(`XCV_REV_DATA_OFS, 32'(v), `XCV_RESP_OKAY);
		axw(`XCV_FWD_DATA_OFS, 32'h0000_0001, `XCV_RESP_SLVERR);
		axr(5'h14, 0, `XCV_RESP_SLVERR);
		axr(`XCV_CTRL_OFS, 32'h0000_0008, `XCV_RESP_OKAY);
		finish_test();
	end
endmodule // tb_top
`default_nettype wire

/* testbench/xcv_bus_partner.sv */
// Far-side bus party for one data port
`default_nettype none
module xcv_bus_partner
(
	input wire logic clock_in,
	input wire logic drive_in,
	input wire xcv_pkg::xcv_data_t value_in,
	input wire xcv_pkg::xcv_data_t dev_in,
	input wire xcv_pkg::xcv_data_t dev_oe_in,
	output var xcv_pkg::xcv_data_t wire_out
);
	timeunit 1ns;
	timeprecision 100ps;
	import xcv_pkg::*;
	xcv_data_t last;
	// Released wire shows the inverse of its last level
	assign wire_out = dev_oe_in[0] ? dev_in : (drive_in ? value_in : ~last);
	// Last driven level
	always_ff @(posedge clock_in)
		if (dev_oe_in[0] || drive_in)
			last <= wire_out;
endmodule // xcv_bus_partner
`default_nettype wire

/* testbench/xcv_properties.sv */
// Port-level checks for the transceiver
`include "xcv_regs.svh"
`default_nettype none
module xcv_properties
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic [`XCV_DATA_W-1:0] a_data_oe_out,
	input wire logic [`XCV_DATA_W-1:0] b_data_oe_out,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic s_axi_arready_out,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clock_in);
	endclocking
	default disable iff (!rst_n_in);
	// Port drivers switch as a whole
	a_b_oe_whole: assert property (b_data_oe_out == '0 || b_data_oe_out == '1)
		else $error("B enables split");
	a_a_oe_whole: assert property (a_data_oe_out == '0 || a_data_oe_out == '1)
		else $error("A enables split");
	// Bus answers and blocking
	a_write_answer: assert property ($fell(s_axi_awready_out) |-> !s_axi_bvalid_out ##1 s_axi_bvalid_out)
		else $error("late write answer");
	a_read_answer: assert property ($fell(s_axi_arready_out) |-> s_axi_rvalid_out)
		else $error("late read answer");
	a_write_block: assert property (s_axi_bvalid_out |-> !s_axi_awready_out)
		else $error("write not blocked");
	a_read_block: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("read not blocked");
	a_write_done: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out && s_axi_awready_out)
		else $error("write not closed");
	a_read_done: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out && s_axi_arready_out)
		else $error("read not closed");
	c_write: cover property (s_axi_bvalid_out && s_axi_bready_in);
	c_read: cover property (s_axi_rvalid_out && s_axi_rready_in);
	c_b_drive: cover property (b_data_oe_out[0]);
	c_a_drive: cover property (a_data_oe_out[0]);
endmodule // xcv_properties
bind xcv_transceiver xcv_properties i_xcv_properties (.clock_in, .rst_n_in, .a_data_oe_out, .b_data_oe_out,
	.s_axi_awready_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arready_out, .s_axi_rvalid_out,
	.s_axi_rready_in);
`default_nettype wire
